/* common/tts_regs.vh */
`ifndef TTS_REGS_VH
`define TTS_REGS_VH

`define TTS_UPD_SIG    12'h08b
`define TTS_MISC_EN    12'h1a0
`define TTS_MISC_RST   64'h0000000000000008
`define TTS_MISC_TM_EN 3
`define TTS_DBG_PAGE   10'h0c0
`define TTS_DBG_STAT   12'h306
`define TTS_DBG_CTL    12'h307
`define TTS_DBG_BHS_EN 8
`define TTS_BHS_PAGE   10'h0d0
`define TTS_LVT_MASK   12'h310
`define TTS_THROTTLE   12'h330
`define TTS_THR_EN     4
`define TTS_THR_DUTY   3:1
`define TTS_THERM_DUTY 3'h4
`define TTS_PCTL_PAGE  10'h0c8
`define TTS_PCNT_PAGE  10'h0ca
`define TTS_PC_EN      0
`define TTS_PC_TID     1
`define TTS_PC_EVT     4:2
`define TTS_PC_IRQ     5
`define TTS_MASK_BIT   20

`define TTS_SK_LOCAL   3'h0
`define TTS_SK_MSRW    3'h1
`define TTS_SK_WBI     3'h2
`define TTS_SK_DISC    3'h3
`define TTS_SK_LFL     3'h4
`define TTS_SK_CRCD    3'h5

`define TTS_CO_NONE    2'h0
`define TTS_CO_WBI     2'h1
`define TTS_CO_DISC    2'h2
`define TTS_CO_LFL     2'h3
`endif

/* design/tts_ctrl.v */
`timescale 1ns/1ps
`include "tts_regs.vh"
module tts_ctrl #(
  parameter AW  = 32,
  parameter DW  = 32,
  parameter CW  = 40,
  parameter BHS = 4,
  parameter XN  = 8,
  parameter VW  = 20,
  parameter PW  = 20
) (
  input  wire            ref_clk,
  input  wire            rst_n,
  input  wire            msr_rd,
  input  wire            msr_wr,
  input  wire            msr_tid,
  input  wire [11:0]     msr_addr,
  input  wire [63:0]     msr_wdata,
  output reg  [63:0]     msr_rdata,
  output reg             msr_ack,
  input  wire [1:0]      ser_req,
  input  wire [5:0]      ser_kind,
  input  wire [2*AW-1:0] lf_addr,
  output reg  [1:0]      ser_done,
  output wire [1:0]      thread_stall,
  input  wire [1:0]      cr_move,
  input  wire [1:0]      cr_cdis,
  output wire            cache_disable,
  output reg  [1:0]      cache_op,
  output reg  [AW-1:0]   cache_addr,
  input  wire            cache_done,
  output reg             bus_cyc_valid,
  output reg  [1:0]      bus_cyc_kind,
  output reg  [AW-1:0]   bus_cyc_addr,
  input  wire [1:0]      st_valid,
  input  wire [2*AW-1:0] st_addr,
  input  wire [2*DW-1:0] st_data,
  output wire [1:0]      st_ready,
  input  wire [1:0]      ld_valid,
  input  wire [2*AW-1:0] ld_addr,
  output wire [1:0]      ld_hit,
  output wire [2*DW-1:0] ld_data,
  output reg             mem_req,
  output reg             mem_tid,
  output reg  [AW-1:0]   mem_addr,
  output reg  [DW-1:0]   mem_data,
  input  wire            mem_ack,
  input  wire [1:0]      br_taken,
  input  wire [2*AW-1:0] br_from,
  input  wire [15:0]     perf_evt,
  output wire [1:0]      perf_irq,
  input  wire [1:0]      uc_req,
  output reg  [1:0]      uc_grant,
  input  wire            uc_done,
  input  wire [31:0]     uc_rev,
  input  wire            cat_trip,
  input  wire            therm_trip,
  output reg             core_halt,
  output reg             core_clk_en,
  input  wire            stop_clock_in_n,
  output reg             stop_grant,
  input  wire            snoop_req,
  output reg             snoop_ack,
  input  wire            local_irq_in_0,
  input  wire            local_irq_in_1,
  output wire [1:0]      lint0_irq,
  output wire [1:0]      local_irq_in_1_irq,
  input  wire            addr_bit_mask_in_n,
  input  wire            fill_en,
  input  wire            fill_tid,
  input  wire            fill_instr,
  input  wire            fill_global,
  input  wire [VW-1:0]   fill_vpn,
  input  wire [PW-1:0]   fill_ppn,
  input  wire            dx_tid,
  input  wire [VW-1:0]   dx_vpn,
  output wire            dx_hit,
  output wire [PW-1:0]   dx_ppn,
  input  wire [2*VW-1:0] ix_vpn,
  output wire [1:0]      ix_hit,
  output wire [2*PW-1:0] ix_ppn,
  input  wire [1:0]      xlat_flush,
  input  wire [1:0]      page_translation_drop,
  input  wire [2*VW-1:0] drop_vpn
);
  localparam BP = $clog2(BHS);
  localparam [2:0] S_IDLE  = 3'h0;
  localparam [2:0] S_DRAIN = 3'h1;
  localparam [2:0] S_CACHE = 3'h2;
  localparam [2:0] S_DONE  = 3'h3;

  function [AW-1:0] amask;
    input [AW-1:0] a;
    input          m;
    begin
      amask = a;
      if (m)
        amask[`TTS_MASK_BIT] = 1'b0;
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  reg  [5:0] sy1;
  reg  [5:0] sy2;
  wire [5:0] raw = {stop_clock_in_n, local_irq_in_0, local_irq_in_1,
                    addr_bit_mask_in_n, cat_trip, therm_trip};
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sy1 <= 6'h24;
      sy2 <= 6'h24;
    end
    else
    begin
      sy1 <= raw;
      sy2 <= sy1;
    end
  end
  wire stop_s = ~sy2[5];
  wire l0_s   = sy2[4];
  wire l1_s   = sy2[3];
  wire a20_s  = ~sy2[2];
  wire cat_s  = sy2[1];
  wire thm_s  = sy2[0];

  //////////////////////////////////////////////////////////////////////////
  // Per-thread state, plus the shared data translation buffer
  reg  [63:0]     misc_feature_enable;
  reg  [2:0]      ss;
  reg             own;
  reg  [2:0]      kd;
  wire [1:0]      pick;
  wire [1:0]      sb_vv;
  wire [1:0]      pend_v;
  wire [5:0]      pend_k;
  wire [1:0]      cdis_v;
  wire [5:0]      duty;
  wire [127:0]    thr_rd;
  wire [2*AW-1:0] sb_av;
  wire [2*DW-1:0] sb_dv;

  genvar t;
  genvar i;
  generate
    for (t = 0; t < 2; t = t + 1)
    begin : g_thr
      localparam [0:0] TID = t;
      reg           sb_v;
      reg  [AW-1:0] sb_a;
      reg  [DW-1:0] sb_d;
      reg  [AW-1:0] dbg_a [0:3];
      reg  [8:0]    debug_control_reg;
      reg  [3:0]    debug_status_reg;
      reg  [AW-1:0] branch_history_stack [0:BHS-1];
      reg  [BP-1:0] bhs_p;
      reg  [4:0]    thread_clock_throttle;
      reg  [1:0]    lvt_mask;
      reg  [31:0]   sig_lo;
      reg  [31:0]   sig_hi;
      reg           cache_disable_flag;
      reg           pend;
      reg  [2:0]    pk;
      reg           l0q;
      reg           l1q;
      reg           ldh;
      reg  [DW-1:0] ldd;
      reg  [63:0]   rdv;
      wire          wr  = msr_wr & (msr_tid == TID);
      wire [AW-1:0] sa  = st_addr[t*AW +: AW];
      wire          acc = st_valid[t] & ~sb_v;
      wire          chg = cr_move[t] & (cr_cdis[t] != cache_disable_flag);
      wire [BP-1:0] bi  = bhs_p - msr_addr[BP-1:0] - 1'b1;
      wire [3:0]    bp_hit;
      integer       k;
      for (i = 0; i < 4; i = i + 1)
      begin : g_bp
        assign bp_hit[i] = acc & debug_control_reg[i] & (sa == dbg_a[i]);
      end

      always @(posedge ref_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          for (k = 0; k < 4; k = k + 1)
            dbg_a[k] <= {AW{1'b0}};
          for (k = 0; k < BHS; k = k + 1)
            branch_history_stack[k] <= {AW{1'b0}};
          debug_control_reg     <= 9'h000;
          debug_status_reg      <= 4'h0;
          bhs_p                 <= {BP{1'b0}};
          thread_clock_throttle <= 5'h00;
          lvt_mask              <= 2'h0;
          sig_lo                <= 32'h00000000;
          sig_hi                <= 32'h00000000;
          cache_disable_flag    <= 1'b0;
          sb_v                  <= 1'b0;
          sb_a                  <= {AW{1'b0}};
          sb_d                  <= {DW{1'b0}};
          pend                  <= 1'b0;
          pk                    <= `TTS_SK_LOCAL;
          l0q                   <= 1'b0;
          l1q                   <= 1'b0;
          ldh                   <= 1'b0;
          ldd                   <= {DW{1'b0}};
        end
        else
        begin
          if (wr && msr_addr[11:2] == `TTS_DBG_PAGE)
            dbg_a[msr_addr[1:0]] <= msr_wdata[AW-1:0];
          if (wr && msr_addr == `TTS_DBG_CTL)
            debug_control_reg <= msr_wdata[8:0];
          // A hit in the cycle software writes status is kept
          debug_status_reg <= ((wr && msr_addr == `TTS_DBG_STAT) ?
                               msr_wdata[3:0] : debug_status_reg) | bp_hit;
          if (br_taken[t] & debug_control_reg[`TTS_DBG_BHS_EN])
          begin
            branch_history_stack[bhs_p] <= br_from[t*AW +: AW];
            bhs_p <= bhs_p + 1'b1;
          end
          if (wr && msr_addr == `TTS_THROTTLE)
            thread_clock_throttle <= msr_wdata[4:0];
          if (wr && msr_addr == `TTS_LVT_MASK)
            lvt_mask <= msr_wdata[1:0];
          if (wr && msr_addr == `TTS_UPD_SIG)
            sig_lo <= msr_wdata[31:0];
          if (uc_done & |uc_grant)
            sig_hi <= uc_rev;
          if (cr_move[t])
            cache_disable_flag <= cr_cdis[t];
          if (acc)
          begin
            sb_v <= 1'b1;
            sb_a <= sa;
            sb_d <= st_data[t*DW +: DW];
          end
          else if (mem_req & mem_ack & (mem_tid == TID))
            sb_v <= 1'b0;
          ldh <= ld_valid[t] & sb_v & (sb_a == ld_addr[t*AW +: AW]);
          ldd <= sb_d;
          if (ser_req[t])
          begin
            pend <= 1'b1;
            pk   <= ser_kind[t*3 +: 3];
          end
          else if (chg)
          begin
            pend <= 1'b1;
            pk   <= `TTS_SK_CRCD;
          end
          else if (pick[t])
            pend <= 1'b0;
          l0q <= l0_s & ~lvt_mask[0] & ~stop_grant;
          l1q <= l1_s & ~lvt_mask[1] & ~stop_grant;
        end
      end

      always @*
      begin
        rdv = 64'h0;
        if (msr_addr[11:2] == `TTS_DBG_PAGE)
          rdv[AW-1:0] = dbg_a[msr_addr[1:0]];
        if (msr_addr[11:2] == `TTS_BHS_PAGE)
          rdv[AW-1:0] = branch_history_stack[bi];
        case (msr_addr)
          `TTS_DBG_STAT: rdv[3:0] = debug_status_reg;
          `TTS_DBG_CTL:  rdv[8:0] = debug_control_reg;
          `TTS_THROTTLE: rdv[4:0] = thread_clock_throttle;
          `TTS_LVT_MASK: rdv[1:0] = lvt_mask;
          `TTS_UPD_SIG:  rdv      = {sig_hi, sig_lo};
          default:       rdv[0]   = 1'b0;
        endcase
      end

      assign thr_rd[t*64 +: 64] = rdv;
      assign sb_vv[t]           = sb_v;
      assign sb_av[t*AW +: AW]  = sb_a;
      assign sb_dv[t*DW +: DW]  = sb_d;
      assign st_ready[t]        = ~sb_v;
      assign ld_hit[t]          = ldh;
      assign ld_data[t*DW +: DW] = ldd;
      assign pend_v[t]          = pend;
      assign pend_k[t*3 +: 3]   = pk;
      assign cdis_v[t]          = cache_disable_flag;
      assign duty[t*3 +: 3]     = thread_clock_throttle[`TTS_THR_EN] ?
                                  thread_clock_throttle[`TTS_THR_DUTY] : 3'h0;
      assign lint0_irq[t]       = l0q;
      assign local_irq_in_1_irq[t]       = l1q;

      tts_xlat_buf #(.N(XN), .VW(VW), .PW(PW)) u_ixl (
        .clk         (ref_clk),
        .rst_n       (rst_n),
        .fill_en     (fill_en & fill_instr & (fill_tid == TID)),
        .fill_tid    (TID),
        .fill_global (fill_global),
        .fill_vpn    (fill_vpn),
        .fill_ppn    (fill_ppn),
        .lk_tid      (TID),
        .lk_vpn      (ix_vpn[t*VW +: VW]),
        .lk_hit      (ix_hit[t]),
        .lk_ppn      (ix_ppn[t*PW +: PW]),
        .flush_all   (xlat_flush),
        .drop        (page_translation_drop),
        .drop_vpn    (drop_vpn)
      );
    end
  endgenerate

  tts_xlat_buf #(.N(XN), .VW(VW), .PW(PW)) u_dxl (
    .clk         (ref_clk),
    .rst_n       (rst_n),
    .fill_en     (fill_en & ~fill_instr),
    .fill_tid    (fill_tid),
    .fill_global (fill_global),
    .fill_vpn    (fill_vpn),
    .fill_ppn    (fill_ppn),
    .lk_tid      (dx_tid),
    .lk_vpn      (dx_vpn),
    .lk_hit      (dx_hit),
    .lk_ppn      (dx_ppn),
    .flush_all   (xlat_flush),
    .drop        (page_translation_drop),
    .drop_vpn    (drop_vpn)
  );

  //////////////////////////////////////////////////////////////////////////
  // Shared performance counters, owned per thread by their control
  wire [127:0] pc_rd;
  wire [3:0]   pc_irq;
  generate
    for (i = 0; i < 2; i = i + 1)
    begin : g_pc
      localparam [1:0] IX = i;
      reg  [7:0]    ctl;
      reg  [CW-1:0] cnt;
      reg  [1:0]    pi;
      wire ev = ctl[`TTS_PC_EN] &
                perf_evt[{ctl[`TTS_PC_TID], ctl[`TTS_PC_EVT]}];
      wire cw = msr_wr & (msr_addr == {`TTS_PCTL_PAGE, IX});
      wire nw = msr_wr & (msr_addr == {`TTS_PCNT_PAGE, IX});
      always @(posedge ref_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          ctl <= 8'h00;
          cnt <= {CW{1'b0}};
          pi  <= 2'h0;
        end
        else
        begin
          if (cw)
            ctl <= msr_wdata[7:0];
          if (nw)
            cnt <= msr_wdata[CW-1:0];
          else if (ev)
            cnt <= cnt + 1'b1;
          pi <= (ev & (&cnt) & ctl[`TTS_PC_IRQ]) ?
                (ctl[`TTS_PC_TID] ? 2'h2 : 2'h1) : 2'h0;
        end
      end
      assign pc_irq[i*2 +: 2] = pi;
      assign pc_rd[i*64 +: 64] =
        (msr_addr == {`TTS_PCTL_PAGE, IX}) ? {56'h0, ctl} :
        (msr_addr == {`TTS_PCNT_PAGE, IX}) ? {{(64-CW){1'b0}}, cnt} :
        64'h0;
    end
  endgenerate
  assign perf_irq = pc_irq[1:0] | pc_irq[3:2];

  //////////////////////////////////////////////////////////////////////////
  // Model register port
  wire [63:0] misc_rd = (msr_addr == `TTS_MISC_EN) ? misc_feature_enable :
                        64'h0;
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      misc_feature_enable <= `TTS_MISC_RST;
      msr_rdata           <= 64'h0;
      msr_ack             <= 1'b0;
    end
    else
    begin
      msr_ack <= msr_rd | msr_wr;
      if (msr_wr && msr_addr == `TTS_MISC_EN)
        misc_feature_enable <= msr_wdata;
      if (msr_rd)
        msr_rdata <= (msr_tid ? thr_rd[127:64] : thr_rd[63:0]) |
                     pc_rd[63:0] | pc_rd[127:64] | misc_rd;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Serialization and cache maintenance
  reg  rr;
  wire glob = (kd == `TTS_SK_MSRW) | (kd == `TTS_SK_WBI) |
              (kd == `TTS_SK_DISC) | (kd == `TTS_SK_CRCD);
  wire [1:0] smask = (ss == S_IDLE) ? 2'h0 : glob ? 2'h3 :
                     (own ? 2'h2 : 2'h1);
  assign pick = (ss != S_IDLE) ? 2'h0 :
                (pend_v == 2'h3) ? (rr ? 2'h2 : 2'h1) : pend_v;
  assign thread_stall = smask | pend_v | {2{stop_grant | core_halt}};
  assign cache_disable = |cdis_v;

  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ss            <= S_IDLE;
      own           <= 1'b0;
      kd            <= `TTS_SK_LOCAL;
      rr            <= 1'b0;
      ser_done      <= 2'h0;
      cache_op      <= `TTS_CO_NONE;
      cache_addr    <= {AW{1'b0}};
      bus_cyc_valid <= 1'b0;
      bus_cyc_kind  <= `TTS_CO_NONE;
      bus_cyc_addr  <= {AW{1'b0}};
    end
    else
    begin
      ser_done      <= 2'h0;
      bus_cyc_valid <= 1'b0;
      case (ss)
        S_IDLE:
          if (|pick)
          begin
            own <= pick[1];
            kd  <= pick[1] ? pend_k[5:3] : pend_k[2:0];
            rr  <= ~pick[1];
            cache_addr <= amask(pick[1] ? lf_addr[2*AW-1:AW] :
                                lf_addr[AW-1:0], a20_s);
            ss  <= S_DRAIN;
          end
        // Stalled threads must empty their store buffers first
        S_DRAIN:
          if ((sb_vv & smask) == 2'h0)
          begin
            if (kd == `TTS_SK_WBI)
              cache_op <= `TTS_CO_WBI;
            else if (kd == `TTS_SK_DISC)
              cache_op <= `TTS_CO_DISC;
            else if (kd == `TTS_SK_LFL)
              cache_op <= `TTS_CO_LFL;
            if (kd == `TTS_SK_WBI || kd == `TTS_SK_DISC ||
                kd == `TTS_SK_LFL)
              ss <= S_CACHE;
            else
              ss <= S_DONE;
          end
        S_CACHE:
          if (cache_done)
          begin
            cache_op      <= `TTS_CO_NONE;
            bus_cyc_valid <= 1'b1;
            bus_cyc_kind  <= cache_op;
            bus_cyc_addr  <= cache_addr;
            ss            <= S_DONE;
          end
        S_DONE:
        begin
          ser_done <= own ? 2'h2 : 2'h1;
          ss       <= S_IDLE;
        end
        default:
          ss <= S_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Store drain, update arbitration, thermal and clock control
  reg        mrr;
  reg        urr;
  reg  [2:0] phase;
  wire       msel = (sb_vv == 2'h3) ? mrr : sb_vv[1];
  wire [2:0] sw   = (duty[5:3] > duty[2:0]) ? duty[5:3] : duty[2:0];
  // Thermal trip only ever slows the clock further than software asks
  wire       tm   = thm_s & misc_feature_enable[`TTS_MISC_TM_EN];
  wire [2:0] eff  = (tm && (sw == 3'h0 || `TTS_THERM_DUTY < sw)) ?
                    `TTS_THERM_DUTY : sw;
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mem_req     <= 1'b0;
      mem_tid     <= 1'b0;
      mem_addr    <= {AW{1'b0}};
      mem_data    <= {DW{1'b0}};
      mrr         <= 1'b0;
      uc_grant    <= 2'h0;
      urr         <= 1'b0;
      core_halt   <= 1'b0;
      core_clk_en <= 1'b0;
      phase       <= 3'h0;
      stop_grant  <= 1'b0;
      snoop_ack   <= 1'b0;
    end
    else
    begin
      if (!mem_req)
      begin
        if (|sb_vv)
        begin
          mem_req  <= 1'b1;
          mem_tid  <= msel;
          mem_addr <= amask(msel ? sb_av[2*AW-1:AW] : sb_av[AW-1:0],
                            a20_s);
          mem_data <= msel ? sb_dv[2*DW-1:DW] : sb_dv[DW-1:0];
          mrr      <= ~msel;
        end
      end
      else if (mem_ack)
        mem_req <= 1'b0;
      if (uc_grant == 2'h0)
      begin
        if (uc_req == 2'h3)
        begin
          uc_grant <= urr ? 2'h2 : 2'h1;
          urr      <= ~urr;
        end
        else
          uc_grant <= uc_req;
      end
      else if (uc_done)
        uc_grant <= 2'h0;
      core_halt   <= core_halt | cat_s;
      phase       <= phase + 1'b1;
      core_clk_en <= ~core_halt & (eff == 3'h0 || phase < eff);
      stop_grant  <= stop_s;
      snoop_ack   <= snoop_req;
    end
  end
endmodule

/* design/tts_xlat_buf.v */
`timescale 1ns/1ps
module tts_xlat_buf #(
  parameter N  = 8,
  parameter VW = 20,
  parameter PW = 20
) (
  input  wire            clk,
  input  wire            rst_n,
  input  wire            fill_en,
  input  wire            fill_tid,
  input  wire            fill_global,
  input  wire [VW-1:0]   fill_vpn,
  input  wire [PW-1:0]   fill_ppn,
  input  wire            lk_tid,
  input  wire [VW-1:0]   lk_vpn,
  output reg             lk_hit,
  output reg  [PW-1:0]   lk_ppn,
  input  wire [1:0]      flush_all,
  input  wire [1:0]      drop,
  input  wire [2*VW-1:0] drop_vpn
);
  localparam IW = $clog2(N);
  reg  [IW-1:0] vic;
  wire [N-1:0]  hit;
  wire [N*PW-1:0] ppn_v;
  integer k;

  genvar e;
  generate
    for (e = 0; e < N; e = e + 1)
    begin : g_ent
      localparam [IW-1:0] IX = e;
      reg          v;
      reg          tg;
      reg          gl;
      reg [VW-1:0] vpn;
      reg [PW-1:0] ppn;
      wire dv = drop[tg] & (drop_vpn[tg*VW +: VW] == vpn);
      always @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          v   <= 1'b0;
          tg  <= 1'b0;
          gl  <= 1'b0;
          vpn <= {VW{1'b0}};
          ppn <= {PW{1'b0}};
        end
        else if (fill_en && vic == IX)
        begin
          v   <= 1'b1;
          tg  <= fill_tid;
          gl  <= fill_global;
          vpn <= fill_vpn;
          ppn <= fill_ppn;
        end
        // Global pages are not spared: the tag alone decides
        else if (flush_all[tg] | dv)
          v <= 1'b0;
      end
      assign hit[e] = v & (tg == lk_tid) & (vpn == lk_vpn);
      assign ppn_v[e*PW +: PW] = ppn;
    end
  endgenerate

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      vic    <= {IW{1'b0}};
      lk_hit <= 1'b0;
      lk_ppn <= {PW{1'b0}};
    end
    else
    begin
      if (fill_en)
        vic <= vic + 1'b1;
      lk_hit <= |hit;
      for (k = N - 1; k >= 0; k = k - 1)
        if (hit[k])
          lk_ppn <= ppn_v[k*PW +: PW];
    end
  end
endmodule

/* tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  logic ref_clk = 0, rst_n = 0, msr_rd = 0, msr_wr = 0, msr_tid = 0;
  logic uc_done = 0, cat_trip = 0, therm_trip = 0, snoop_req = 0, dx_tid = 0;
  logic stop_clock_in_n = 1, addr_bit_mask_in_n = 1, fill_en = 0;
  logic local_irq_in_0 = 0, local_irq_in_1 = 0, fill_tid = 0;
  logic fill_instr = 0, fill_global = 0;
  logic [1:0] ser_req = 0, cr_move = 0, cr_cdis = 0, st_valid = 0;
  logic [1:0] ld_valid = 0, br_taken = 0, uc_req = 0, xlat_flush = 0;
  logic [1:0] page_translation_drop = 0;
  logic [3:0] dly = 0;
  logic [5:0] ser_kind = 0;
  logic [11:0] msr_addr = 0;
  logic [15:0] perf_evt = 0;
  logic [19:0] fill_vpn = 0, fill_ppn = 0, dx_vpn = 0;
  logic [31:0] uc_rev = 0;
  logic [39:0] ix_vpn = 0, drop_vpn = 0;
  logic [63:0] msr_wdata = 0, lf_addr = 0, st_addr = 0, st_data = 0;
  logic [63:0] ld_addr = 0, br_from = 0, rd;
  wire msr_ack, cache_disable, cache_done, bus_cyc_valid, mem_req, mem_ack;
  wire mem_tid, core_halt, core_clk_en, stop_grant, snoop_ack, dx_hit;
  wire [1:0] ser_done, thread_stall, cache_op, bus_cyc_kind, st_ready;
  wire [1:0] ld_hit, perf_irq, uc_grant, lint0_irq, local_irq_in_1_irq, ix_hit;
  wire [19:0] dx_ppn;
  wire [31:0] cache_addr, bus_cyc_addr, mem_addr, mem_data;
  wire [39:0] ix_ppn;
  wire [63:0] msr_rdata, ld_data;
  integer fails = 0, checked = 0, i, n;
  tts_ctrl tts_ctrl_inst (.*);
  tts_far tts_far_inst (.*);
  always #20 ref_clk = ~ref_clk;
  task wt(input integer n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task chk(input [63:0] got, input [63:0] exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task msr(input w, input t, input [11:0] a, input [63:0] d);
    msr_wr = w;
    msr_rd = !w;
    msr_tid = t;
    msr_addr = a;
    msr_wdata = d;
    wt(1);
    msr_wr = 0;
    msr_rd = 0;
    rd = msr_rdata;
    chk(msr_ack, 1);
    wt(1);
  endtask
  task wdone(input t);
    for (i = 0; i < 60 && ser_done[t] !== 1'b1; i++)
      wt(1);
    chk(ser_done[t], 1);
    wt(2);
  endtask
  task ser(input [5:0] kd, input [1:0] rq);
    ser_kind = kd;
    ser_req = rq;
    wt(1);
    ser_req = 0;
    wt(1);
  endtask
  task count_en(input [63:0] exp);
    n = 0;
    repeat (8)
    begin
      n += core_clk_en;
      wt(1);
    end
    chk(n, exp);
  endtask
  task stop_test;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    wt(6);
    rst_n = 1;
    wt(1);
    msr(0, 1, 12'h1a0, 0);
    chk(rd, 64'h8);
    msr(1, 1, 12'h1a0, 64'h18);
    msr(0, 0, 12'h1a0, 0);
    chk(rd, 64'h18);
    msr(1, 0, 12'h300, 64'h1234);
    msr(0, 1, 12'h300, 0);
    chk(rd, 64'h0);
    msr(0, 0, 12'h123, 0);
    chk(rd, 64'h0);
    msr(1, 1, 12'h320, 64'h1);
    perf_evt = 16'h1;
    wt(3);
    perf_evt = 0;
    msr(0, 0, 12'h328, 0);
    chk(rd, 64'h3);
    $display("registers done");
    cr_cdis = 2'h2;
    cr_move = 2'h2;
    wt(1);
    cr_move = 0;
    wdone(1);
    chk(cache_disable, 1);
    ser(6'h0, 2'h1);
    chk(thread_stall, 2'h1);
    wdone(0);
    ser(6'h8, 2'h2);
    chk(thread_stall, 2'h3);
    wdone(1);
    lf_addr = 64'h1240;
    // Kinds 2..4 map to bus cycle codes 1..3, partner ever slower
    for (int k = 2; k < 5; k++)
    begin
      dly = 4'(k * 3 - 6);
      ser(6'(k), 2'h1);
      wdone(0);
      chk(bus_cyc_kind, k - 1);
      chk(bus_cyc_addr, 32'h1240);
    end
    $display("cache ops done");
    uc_rev = 32'h5a5a0001;
    uc_req = 2'h3;
    for (i = 0; i < 20 && uc_grant === 2'h0; i++)
      wt(1);
    uc_req = 0;
    uc_done = 1;
    wt(1);
    uc_done = 0;
    wt(2);
    msr(0, 0, 12'h08b, 0);
    chk(rd, {uc_rev, 32'h0});
    msr(0, 1, 12'h08b, 0);
    chk(rd, {uc_rev, 32'h0});
    fill_global = 1;
    fill_vpn = 20'h5;
    fill_ppn = 20'h9;
    fill_en = 1;
    wt(1);
    fill_tid = 1;
    fill_ppn = 20'h7;
    wt(1);
    fill_instr = 1;
    wt(1);
    fill_en = 0;
    xlat_flush = 2'h1;
    dx_tid = 1;
    dx_vpn = 20'h5;
    ix_vpn = {20'h5, 20'h5};
    wt(1);
    xlat_flush = 0;
    wt(1);
    chk({ix_hit, dx_hit, dx_ppn}, {3'h5, 20'h7});
    dx_tid = 0;
    wt(2);
    chk(dx_hit, 0);
    $display("buffers done");
    addr_bit_mask_in_n = 0;
    wt(6);
    st_addr = 64'h0010_0040;
    st_data = 64'h77;
    st_valid = 2'h1;
    wt(1);
    st_valid = 0;
    ld_valid = 2'h1;
    ld_addr = st_addr;
    for (i = 0; i < 20 && mem_req !== 1'b1; i++)
      wt(1);
    chk({ld_hit, st_ready, ld_data[31:0]}, {4'h6, 32'h77});
    chk({mem_tid, mem_data}, {1'b0, 32'h77});
    chk(mem_addr, 32'h40);
    ld_valid = 0;
    wt(8);
    stop_clock_in_n = 0;
    wt(4);
    chk(stop_grant, 1);
    snoop_req = 1;
    wt(1);
    snoop_req = 0;
    chk(snoop_ack, 1);
    stop_clock_in_n = 1;
    msr(1, 1, 12'h310, 64'h1);
    local_irq_in_0 = 1;
    local_irq_in_1 = 1;
    wt(4);
    chk({lint0_irq, local_irq_in_1_irq}, 4'h7);
    msr(1, 0, 12'h330, 64'h14);
    msr(1, 1, 12'h330, 64'h16);
    count_en(3);
    therm_trip = 1;
    msr(1, 1, 12'h330, 64'h1e);
    wt(2);
    count_en(4);
    cat_trip = 1;
    wt(4);
    chk(core_halt, 1);
    $display("pins done");
    stop_test;
  end
  initial
  begin
    #400000;
    fails++;
    stop_test;
  end
endmodule

/* tb/tts_chk.sv */
`timescale 1ns/1ps
module tts_chk #(
  parameter AW = 32
) (
  input wire          ref_clk,
  input wire          rst_n,
  input wire          snoop_req,
  input wire          snoop_ack,
  input wire          stop_clock_in_n,
  input wire          stop_grant,
  input wire          cat_trip,
  input wire          core_halt,
  input wire          cache_done,
  input wire          bus_cyc_valid,
  input wire          mem_req,
  input wire          addr_bit_mask_in_n,
  input wire [1:0]    ser_req,
  input wire [5:0]    ser_kind,
  input wire [1:0]    ser_done,
  input wire [1:0]    thread_stall,
  input wire [1:0]    cache_op,
  input wire [1:0]    uc_grant,
  input wire [AW-1:0] mem_addr
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  property p_snoop; snoop_req |=> snoop_ack; endproperty
  a_snoop: assert property (p_snoop) else $error("snoop unanswered");
  property p_stop; !stop_clock_in_n [*4] |-> stop_grant; endproperty
  a_stop: assert property (p_stop) else $error("no stop grant");
  property p_halt; cat_trip [*4] |-> core_halt; endproperty
  a_halt: assert property (p_halt) else $error("no core halt");
  property p_bus; cache_done && cache_op != 2'h0 |=> bus_cyc_valid; endproperty
  a_bus: assert property (p_bus) else $error("no bus cycle");
  property p_both;
    ser_req[0] && ser_kind[2:0] == 3'h2 && thread_stall == 2'h0
      |-> ##2 thread_stall == 2'h3;
  endproperty
  a_both: assert property (p_both) else $error("one thread ran");
  property p_own; ser_done[0] |-> $past(thread_stall[0]); endproperty
  a_own: assert property (p_own) else $error("done unstalled");
  property p_grant; $onehot0(uc_grant); endproperty
  a_grant: assert property (p_grant) else $error("double grant");
  // Six cycles covers the pin synchronizer plus the store accept
  property p_mask;
    !addr_bit_mask_in_n [*6] ##0 $rose(mem_req) |-> !mem_addr[20];
  endproperty
  a_mask: assert property (p_mask) else $error("bit 20 set");
endmodule
bind tts_ctrl tts_chk #(.AW(AW)) tts_chk_inst (.*);

/* tb/tts_far.sv */
`timescale 1ns/1ps
module tts_far (
  input  wire       ref_clk,
  input  wire [1:0] cache_op,
  input  wire       mem_req,
  input  wire [3:0] dly,
  output reg        cache_done = 1'b0,
  output reg        mem_ack = 1'b0
);
  reg [3:0] cnt = 4'h0;
  // Answers after dly cycles; never acks without a standing request
  always @(posedge ref_clk)
  begin
    cache_done <= 1'b0;
    mem_ack <= 1'b0;
    if ((cache_op != 2'h0 || mem_req) && !cache_done && !mem_ack)
    begin
      cnt <= cnt + 4'h1;
      if (cnt == dly)
      begin
        cnt <= 4'h0;
        cache_done <= cache_op != 2'h0;
        mem_ack <= mem_req;
      end
    end
  end
endmodule
